// File: pacd_regs.sv
// Purpose: advertisement, partner ability and special control/cable diagnostic registers
// Assumes: plain register port, read data one cycle after the read strobe
// Notes: port control and port status registers live elsewhere; only the shared bits answer here
//
// How it works
// R1 - adv bit 8: 100 full, resets 1
// R2 - adv bit 7: 100 half, read/write
// R3 - adv bit 6: 10 full, read/write
// R4 - adv bit 5: 10 half, resets 1
// R5 - adv bits 8..5 shared with port control 3..0
// R6 - adv bit 10: pause, resets 1
// R7 - partner bit 10 pause, read-only, reset 0
// R8 - partner bits 8..5 mirror port status 3..0
// R9 - result field 14..13 encodes cable outcome
// R10 - writing bit 12 starts test, self-clears
// R11 - bit 12 low means results valid
// R12 - bit 9 enables remote loopback, reset 0
// R13 - bits 8..0 read-only fault distance count
// R14 - addresses 0xf0..0xf3 reserved, no function
// R15 - outcome held until next test completes
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "pacd_map.svh"
module pacd_regs #(
    parameter int TIMEOUT_CYC = `PACD_TEST_TIMEOUT
) (
    input wire logic sys_clk, // 40 MHz core clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic [7:0] reg_addr, // register byte address
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output var logic [15:0] reg_rdata, // read data, cycle after reg_rd
    input wire logic [4:0] partner_abil, // partner pause,100f,100h,10f,10h
    output var logic [4:0] adv_abil, // advertised pause,100f,100h,10f,10h
    output var logic remote_loopback, // line rx looped to line tx
    output var logic force_link, // force link bit
    output var logic cable_test_start, // one-cycle start to analog
    input wire logic cable_test_done, // analog test finished pulse
    input wire logic [1:0] cable_test_result, // analog result code
    input wire logic [8:0] cable_test_count, // analog fault count
    output var logic irq // level interrupt, active high
);
    pacd_diag_if diag ();

    pacd_pkg::pacd_abil_t adv_q;
    pacd_pkg::pacd_abil_t adv_d;
    pacd_pkg::pacd_abil_t partner_q;
    logic loop_q;
    logic flink_q;
    logic [`PACD_INT_W-1:0] stat_q;
    logic [`PACD_INT_W-1:0] stat_d;
    logic [`PACD_INT_W-1:0] mask_q;
    logic irq_q;
    logic [15:0] rdata_q;

    // address decode
    wire sel_adv = (reg_addr == `PACD_ADDR_ADV);
    wire sel_lpa = (reg_addr == `PACD_ADDR_LPA);
    wire sel_scd = (reg_addr == `PACD_ADDR_SCD);
    wire sel_pctl = (reg_addr == `PACD_ADDR_PCTL);
    wire sel_pstat = (reg_addr == `PACD_ADDR_PSTAT);
    wire sel_stat = (reg_addr == `PACD_ADDR_INT_STAT);
    wire sel_mask = (reg_addr == `PACD_ADDR_INT_MASK);
    wire sel_rsvd = (reg_addr >= `PACD_ADDR_RSVD_LO) && (reg_addr <= `PACD_ADDR_RSVD_HI);

    wire wr_adv = reg_wr && sel_adv;
    wire wr_pctl = reg_wr && sel_pctl;
    wire wr_scd = reg_wr && sel_scd;
    wire wr_stat = reg_wr && sel_stat;
    wire wr_mask = reg_wr && sel_mask;

    // shared advertisement storage, either address writes it
    wire [4:0] adv_from_adv = {reg_wdata[`PACD_ADV_PAUSE_BIT],
                               reg_wdata[`PACD_ADV_HI_BIT:`PACD_ADV_LO_BIT]};
    wire [4:0] adv_from_pctl = reg_wdata[4:0];
    always_comb begin
        adv_d = adv_q;
        if (wr_adv) begin
            adv_d = adv_from_adv; // R1 R2 R3 R4 R6
        end else if (wr_pctl) begin
            adv_d = adv_from_pctl; // R5
        end
    end

    // cable test start, ignored by the sequencer while a test runs
    assign diag.start = wr_scd && reg_wdata[`PACD_SCD_START_BIT]; // R10

    // sticky events: set beats write-one-clear
    wire lpa_chg = (partner_abil != partner_q);
    wire [`PACD_INT_W-1:0] stat_set = {lpa_chg, diag.done};
    wire [`PACD_INT_W-1:0] stat_clr = wr_stat ? reg_wdata[`PACD_INT_W-1:0] : '0;
    assign stat_d = (stat_q & ~stat_clr) | stat_set;
    wire irq_d = |(stat_q & mask_q);

    // read views
    wire [15:0] rd_adv = {5'h00, adv_q[4], 1'b0, adv_q[3:0], `PACD_ADV_SELECTOR};
    wire [15:0] rd_lpa = {5'h00, partner_q[4], 1'b0, partner_q[3:0], `PACD_LPA_LOW}; // R7 R8
    wire [15:0] rd_scd = {1'b0, diag.result, diag.busy, flink_q, 1'b0, loop_q,
                          diag.count}; // R9 R11 R13
    wire [15:0] rd_pctl = {11'h000, adv_q}; // R5
    wire [15:0] rd_pstat = {11'h000, partner_q}; // R7 R8
    wire [15:0] rd_stat = {{(16-`PACD_INT_W){1'b0}}, stat_q};
    wire [15:0] rd_mask = {{(16-`PACD_INT_W){1'b0}}, mask_q};
    wire [15:0] rd_mux = sel_adv ? rd_adv :
                         sel_lpa ? rd_lpa :
                         sel_scd ? rd_scd :
                         sel_pctl ? rd_pctl :
                         sel_pstat ? rd_pstat :
                         sel_stat ? rd_stat :
                         sel_mask ? rd_mask :
                         16'h0000; // R14
    wire [15:0] rdata_d = reg_rd ? rd_mux : 16'h0000;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            adv_q <= `PACD_ADV_RESET;
            partner_q <= 5'h00;
            loop_q <= 1'b0;
            flink_q <= 1'b0;
        end else begin
            adv_q <= adv_d;
            partner_q <= partner_abil; // R7 R8
            if (wr_scd) begin
                loop_q <= reg_wdata[`PACD_SCD_RLB_BIT]; // R12
                flink_q <= reg_wdata[`PACD_SCD_FLINK_BIT];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            stat_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            stat_q <= stat_d;
            if (wr_mask) begin
                mask_q <= reg_wdata[`PACD_INT_W-1:0];
            end
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    pacd_cable_test #(
        .TIMEOUT_CYC(TIMEOUT_CYC)
    ) u_test (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .diag(diag),
        .ana_start(cable_test_start),
        .ana_done(cable_test_done),
        .ana_result(cable_test_result),
        .ana_count(cable_test_count)
    );

    assign reg_rdata = rdata_q;
    assign adv_abil = adv_q;
    assign remote_loopback = loop_q;
    assign force_link = flink_q;
    assign irq = irq_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_adv_write;
        wr_adv |=> adv_abil == {$past(reg_wdata[10]), $past(reg_wdata[8:5])};
    endproperty
    a_adv_write: assert property (p_adv_write) else $error("advert write lost"); // R1 R2 R3 R4 R6

    property p_pctl_share;
        wr_pctl ##1 (reg_rd && sel_adv) |=> reg_rdata[8:5] == $past(reg_wdata[3:0], 2);
    endproperty
    a_pctl_share: assert property (p_pctl_share) else $error("shared bit not seen"); // R5

    property p_lpa_read;
        reg_rd && sel_lpa |=> reg_rdata[10] == $past(partner_q[4])
            && reg_rdata[8:5] == $past(partner_q[3:0]) && reg_rdata[4:0] == 5'h01;
    endproperty
    a_lpa_read: assert property (p_lpa_read) else $error("partner read wrong"); // R7 R8

    property p_lpa_ro;
        reg_wr && (sel_lpa || sel_pstat) |=> $stable(adv_abil) && partner_q == $past(partner_abil);
    endproperty
    a_lpa_ro: assert property (p_lpa_ro) else $error("partner bits written"); // R7

    property p_scd_read;
        reg_rd && sel_scd |=> reg_rdata[14:13] == $past(diag.result)
            && reg_rdata[8:0] == $past(diag.count) && reg_rdata[12] == $past(diag.busy);
    endproperty
    a_scd_read: assert property (p_scd_read) else $error("diag read wrong"); // R9 R11 R13

    property p_start_busy;
        diag.start && !diag.busy |=> diag.busy && cable_test_start;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("test did not start"); // R10

    property p_done_clear;
        diag.busy && cable_test_done |=> !diag.busy ##1 stat_q[0];
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("start bit not self-cleared"); // R10 R11

    property p_loop;
        wr_scd |=> remote_loopback == $past(reg_wdata[9]);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback not written"); // R12

    property p_rsvd;
        reg_rd && sel_rsvd |=> reg_rdata == 16'h0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read nonzero"); // R14

    property p_irq;
        diag.done && mask_q[0] && !wr_mask |=> ##1 irq;
    endproperty
    a_irq: assert property (p_irq) else $error("masked-in event gave no interrupt");

    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

    property p_adv_read;
        reg_rd && sel_adv |=> reg_rdata[10] == $past(adv_abil[4])
            && reg_rdata[8:5] == $past(adv_abil[3:0]) && reg_rdata[4:0] == 5'h01;
    endproperty
    a_adv_read: assert property (p_adv_read) else $error("advert read wrong"); // R1 R2 R3 R4 R6

    property p_pctl_read;
        reg_rd && sel_pctl |=> reg_rdata == {11'h000, $past(adv_abil)};
    endproperty
    a_pctl_read: assert property (p_pctl_read) else $error("control view wrong"); // R5

    property p_pstat_read;
        reg_rd && sel_pstat |=> reg_rdata == {11'h000, $past(partner_q)};
    endproperty
    a_pstat_read: assert property (p_pstat_read) else $error("status view wrong"); // R7 R8

    property p_adv_hold;
        !wr_adv && !wr_pctl |=> $stable(adv_abil);
    endproperty
    a_adv_hold: assert property (p_adv_hold) else $error("advert changed"); // R5

    property p_rsvd_write;
        reg_wr && sel_rsvd |=> $stable(adv_abil) && $stable(remote_loopback) && $stable(mask_q);
    endproperty
    a_rsvd_write: assert property (p_rsvd_write) else $error("reserved write landed"); // R14

    property p_loop_hold;
        !wr_scd |=> $stable(remote_loopback);
    endproperty
    a_loop_hold: assert property (p_loop_hold) else $error("loopback changed"); // R12

    property p_flink;
        wr_scd |=> force_link == $past(reg_wdata[`PACD_SCD_FLINK_BIT]);
    endproperty
    a_flink: assert property (p_flink) else $error("force link not written");

    property p_diag_ro;
        wr_scd && !diag.busy |=> $stable(diag.result) && $stable(diag.count);
    endproperty
    a_diag_ro: assert property (p_diag_ro) else $error("outcome overwritten"); // R9 R13

    property p_start_once;
        cable_test_start |=> !cable_test_start;
    endproperty
    a_start_once: assert property (p_start_once) else $error("start pulse too long"); // R10

    property p_done_once;
        diag.done |=> !diag.done;
    endproperty
    a_done_once: assert property (p_done_once) else $error("done pulse too long"); // R10

    property p_set_wins;
        diag.done && wr_stat && reg_wdata[`PACD_INT_DONE_BIT] |=> stat_q[`PACD_INT_DONE_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle event");

    property p_w1c;
        wr_stat && reg_wdata[`PACD_INT_DONE_BIT] && !diag.done |=> !stat_q[`PACD_INT_DONE_BIT];
    endproperty
    a_w1c: assert property (p_w1c) else $error("status bit not cleared");

    property p_lpa_event;
        rstn && partner_abil != partner_q |=> stat_q[`PACD_INT_LPA_BIT];
    endproperty
    a_lpa_event: assert property (p_lpa_event) else $error("partner change not flagged");

    property p_mask_write;
        wr_mask |=> mask_q == $past(reg_wdata[`PACD_INT_W-1:0]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask not written");

    property p_irq_level;
        irq == $past(|(stat_q & mask_q));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    c_test_done: cover property (diag.start ##[1:20] diag.done);
    c_pctl_write: cover property (wr_pctl ##1 reg_rd && sel_adv);
    c_irq: cover property (irq ##1 wr_stat ##2 !irq);
    c_set_clear: cover property (wr_stat && diag.done);
endmodule : pacd_regs
`default_nettype wire

// File: pacd_map.svh
// Purpose: addresses, bit positions, reset values and counts of the PHY register bank
// Assumes: byte addresses on an 8-bit register port
// Notes: definitions only
`ifndef PACD_MAP_SVH
`define PACD_MAP_SVH

`define PACD_ADDR_ADV 8'hec
`define PACD_ADDR_LPA 8'hee
`define PACD_ADDR_RSVD_LO 8'hf0
`define PACD_ADDR_RSVD_HI 8'hf3
`define PACD_ADDR_SCD 8'hf4
`define PACD_ADDR_PCTL 8'hf6
`define PACD_ADDR_PSTAT 8'hf8
`define PACD_ADDR_INT_STAT 8'h80
`define PACD_ADDR_INT_MASK 8'h82

`define PACD_ADV_PAUSE_BIT 10
`define PACD_ADV_HI_BIT 8
`define PACD_ADV_LO_BIT 5
`define PACD_ADV_RESET 5'h1f
`define PACD_ADV_SELECTOR 5'h01
`define PACD_LPA_LOW 5'h01

`define PACD_SCD_RES_HI 14
`define PACD_SCD_RES_LO 13
`define PACD_SCD_START_BIT 12
`define PACD_SCD_FLINK_BIT 11
`define PACD_SCD_RLB_BIT 9
`define PACD_SCD_CNT_HI 8

`define PACD_INT_DONE_BIT 0
`define PACD_INT_LPA_BIT 1
`define PACD_INT_W 2

`define PACD_TEST_TIMEOUT 65536

`endif

// File: pacd_pkg.sv
// Purpose: types shared by the PHY register bank and its cable test sequencer
// Assumes: nothing
// Notes: constants live in pacd_map.svh
package pacd_pkg;

    typedef logic [4:0] pacd_abil_t;

    typedef enum logic [0:0] {
        PACD_IDLE = 1'b0,
        PACD_RUN = 1'b1
    } pacd_state_e;

    typedef enum logic [1:0] {
        PACD_RES_OK = 2'b00,
        PACD_RES_OPEN = 2'b01,
        PACD_RES_SHORT = 2'b10,
        PACD_RES_FAIL = 2'b11
    } pacd_result_e;

endpackage : pacd_pkg

// File: pacd_diag_if.sv
// Purpose: carries start, progress and outcome between the bank and the cable test sequencer
// Assumes: single clock
// Notes: start and done are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface pacd_diag_if;
    logic start;
    logic done;
    logic busy;
    logic [1:0] result;
    logic [8:0] count;

    modport ctl (output start, input done, input busy, input result, input count);
    modport seq (input start, output done, output busy, output result, output count);
endinterface : pacd_diag_if
`default_nettype wire

// File: pacd_cable_test.sv
// Purpose: runs one cable diagnostic against the analog side and holds its outcome
// Assumes: ana_done is a one-cycle pulse with result and count valid beside it
// Notes: a test that never answers ends as a failed test after TIMEOUT_CYC cycles
`timescale 1ns/1ps
`default_nettype none
`include "pacd_map.svh"
module pacd_cable_test #(
    parameter int TIMEOUT_CYC = `PACD_TEST_TIMEOUT
) (
    input wire logic sys_clk, // core clock
    input wire logic rstn, // synchronous reset, active low
    pacd_diag_if.seq diag, // link to the register bank
    output var logic ana_start, // one-cycle start pulse to analog
    input wire logic ana_done, // analog test finished
    input wire logic [1:0] ana_result, // analog result code
    input wire logic [8:0] ana_count // analog fault distance count
);
    pacd_pkg::pacd_state_e state_q;
    pacd_pkg::pacd_state_e state_d;
    logic [31:0] tmo_q;
    logic done_q;
    logic [1:0] result_q;
    logic [8:0] count_q;

    wire go = (state_q == pacd_pkg::PACD_IDLE) && diag.start;
    wire timeout = (state_q == pacd_pkg::PACD_RUN) && (tmo_q == 32'(TIMEOUT_CYC - 1));
    wire finish = (state_q == pacd_pkg::PACD_RUN) && (ana_done || timeout);
    wire [31:0] tmo_d = (state_q == pacd_pkg::PACD_RUN) ? tmo_q + 32'd1 : 32'd0;
    wire [1:0] result_d = ana_done ? ana_result : pacd_pkg::PACD_RES_FAIL;
    wire [8:0] count_d = ana_done ? ana_count : 9'h000;

    always_comb begin
        case (state_q)
            pacd_pkg::PACD_IDLE: state_d = go ? pacd_pkg::PACD_RUN : pacd_pkg::PACD_IDLE;
            pacd_pkg::PACD_RUN: state_d = finish ? pacd_pkg::PACD_IDLE : pacd_pkg::PACD_RUN;
            default: state_d = pacd_pkg::PACD_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q <= pacd_pkg::PACD_IDLE;
            tmo_q <= 32'd0;
            ana_start <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d; // R10
            tmo_q <= tmo_d;
            ana_start <= go;
            done_q <= finish;
        end
    end

    // outcome held until the next test ends
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            result_q <= 2'b00;
            count_q <= 9'h000;
        end else if (finish) begin
            result_q <= result_d; // R15
            count_q <= count_d; // R15
        end
    end

    assign diag.busy = (state_q == pacd_pkg::PACD_RUN); // R11
    assign diag.done = done_q;
    assign diag.result = result_q;
    assign diag.count = count_q;

    property p_hold;
        @(posedge sys_clk) disable iff (!rstn)
        !finish |=> $stable(result_q) && $stable(count_q);
    endproperty
    a_hold: assert property (p_hold) else $error("outcome changed without a finished test"); // R15

    property p_start_pulse;
        @(posedge sys_clk) disable iff (!rstn)
        go |=> ana_start && diag.busy ##1 !ana_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse malformed"); // R10

    property p_done_idle;
        @(posedge sys_clk) disable iff (!rstn)
        diag.done |-> !diag.busy && $past(diag.busy);
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("done without busy falling"); // R11

    c_timeout: cover property (@(posedge sys_clk) disable iff (!rstn) timeout);
endmodule : pacd_cable_test
`default_nettype wire

// File: pacd_regs_tb.sv
// Purpose: self-checking bench for the PHY advertisement, partner and cable test registers
// Assumes: register port with read data in the cycle after the read strobe
// Notes: test timeout shortened to 16 cycles
`timescale 1ns/1ps
`default_nettype none
`include "pacd_map.svh"
module testbench;
    localparam int TMO = 16;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [4:0] partner_abil = 5'h00;
    logic [4:0] adv_abil;
    logic remote_loopback;
    logic force_link;
    logic cable_test_start;
    logic irq;
    logic cable_test_done = 1'b0;
    logic [1:0] cable_test_result = 2'h0;
    logic [8:0] cable_test_count = 9'h000;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [15:0] rd_val;

    always #12.5 sys_clk = ~sys_clk;

    pacd_regs #(.TIMEOUT_CYC(TMO)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .partner_abil(partner_abil),
        .adv_abil(adv_abil), .remote_loopback(remote_loopback), .force_link(force_link),
        .cable_test_start(cable_test_start), .cable_test_done(cable_test_done),
        .cable_test_result(cable_test_result), .cable_test_count(cable_test_count), .irq(irq)
    );

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
        check(rd_val, exp);
    endtask : rd_chk

    task automatic wr_rd_chk(input logic [7:0] wa, input logic [15:0] d, input logic [7:0] ra,
                             input logic [15:0] exp);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= wa;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= ra;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : wr_rd_chk

    task automatic wait_irq(input logic v);
        for (int k = 0; k < 6 && irq !== v; k++) begin
            @(posedge sys_clk);
            #1;
        end
        check({15'h0, irq}, {15'h0, v});
    endtask : wait_irq

    function automatic logic [15:0] scd(input logic [1:0] res, input logic b, input logic fl,
                                        input logic lb, input logic [8:0] c);
        return {1'b0, res, b, fl, 1'b0, lb, c};
    endfunction : scd

    task automatic t_reset;
        rd_chk(`PACD_ADDR_ADV, 16'h05e1);
        @(posedge sys_clk);
        #1;
        check(reg_rdata, 16'h0000);
        check({11'h0, adv_abil}, 16'h001f);
        rd_chk(`PACD_ADDR_LPA, 16'h0001);
        rd_chk(`PACD_ADDR_SCD, 16'h0000);
        check({14'h0, remote_loopback, irq}, 16'h0000);
    endtask : t_reset

    task automatic t_adv;
        logic [15:0] exp;
        for (int i = 0; i < 5; i++) begin
            wr(`PACD_ADDR_PCTL, 16'(16'h0001 << i));
            exp = (i == 4) ? 16'h0401 : 16'(16'h0001 | (16'h0020 << i));
            rd_chk(`PACD_ADDR_ADV, exp);
            check({11'h0, adv_abil}, 16'(16'h0001 << i));
        end
        wr_rd_chk(`PACD_ADDR_PCTL, 16'h0005, `PACD_ADDR_ADV, 16'h00a1);
        wr(`PACD_ADDR_ADV, 16'hffff);
        rd_chk(`PACD_ADDR_ADV, 16'h05e1);
        rd_chk(`PACD_ADDR_PCTL, 16'h001f);
        wr(`PACD_ADDR_ADV, 16'h0000);
        rd_chk(`PACD_ADDR_PCTL, 16'h0000);
    endtask : t_adv

    task automatic t_partner;
        wr(`PACD_ADDR_INT_STAT, 16'h0003);
        @(posedge sys_clk);
        partner_abil <= 5'h15;
        rd_chk(`PACD_ADDR_LPA, 16'h04a1);
        rd_chk(`PACD_ADDR_PSTAT, 16'h0015);
        wr(`PACD_ADDR_LPA, 16'h0000);
        rd_chk(`PACD_ADDR_LPA, 16'h04a1);
        check({15'h0, irq}, 16'h0000);
        rd_chk(`PACD_ADDR_INT_STAT, 16'h0002);
        wr(`PACD_ADDR_INT_MASK, 16'h0002);
        wait_irq(1'b1);
        wr(`PACD_ADDR_INT_STAT, 16'h0002);
        wait_irq(1'b0);
        @(posedge sys_clk);
        partner_abil <= 5'h0a;
        rd_chk(`PACD_ADDR_LPA, 16'h0141);
        wr(`PACD_ADDR_INT_MASK, 16'h0001);
        wr(`PACD_ADDR_INT_STAT, 16'h0003);
    endtask : t_partner

    task automatic t_rsvd;
        for (int i = 0; i < 4; i++) begin
            wr(8'(`PACD_ADDR_RSVD_LO + i), 16'hffff);
            rd_chk(8'(`PACD_ADDR_RSVD_LO + i), 16'h0000);
        end
        wr(8'h10, 16'hffff);
        rd_chk(8'h10, 16'h0000);
    endtask : t_rsvd

    task automatic t_cable;
        logic [1:0] ores;
        logic [8:0] ocnt;
        logic [8:0] cnt;
        ores = 2'h0;
        ocnt = 9'h000;
        for (int r = 0; r < 4; r++) begin
            cnt = 9'(9'h0a5 + 9'(r * 67));
            wr(`PACD_ADDR_SCD, 16'h1a00);
            check({13'h0, cable_test_start, force_link, remote_loopback}, 16'h0007);
            rd_chk(`PACD_ADDR_SCD, scd(ores, 1'b1, 1'b1, 1'b1, ocnt));
            repeat (3) @(posedge sys_clk);
            cable_test_done <= 1'b1;
            cable_test_result <= 2'(r);
            cable_test_count <= cnt;
            @(posedge sys_clk);
            cable_test_done <= 1'b0;
            rd_chk(`PACD_ADDR_SCD, scd(2'(r), 1'b0, 1'b1, 1'b1, cnt));
            wait_irq(1'b1);
            rd_chk(`PACD_ADDR_INT_STAT, 16'h0001);
            wr(`PACD_ADDR_INT_STAT, 16'h0001);
            wait_irq(1'b0);
            ores = 2'(r);
            ocnt = cnt;
        end
    endtask : t_cable

    task automatic t_timeout;
        wr(`PACD_ADDR_SCD, 16'h1200);
        repeat (TMO + 4) @(posedge sys_clk);
        rd_chk(`PACD_ADDR_SCD, scd(2'h3, 1'b0, 1'b0, 1'b1, 9'h000));
        @(posedge sys_clk);
        cable_test_done <= 1'b1;
        cable_test_result <= 2'h1;
        cable_test_count <= 9'h1ff;
        @(posedge sys_clk);
        cable_test_done <= 1'b0;
        rd_chk(`PACD_ADDR_SCD, scd(2'h3, 1'b0, 1'b0, 1'b1, 9'h000));
        wr(`PACD_ADDR_SCD, 16'h0000);
        check({15'h0, remote_loopback}, 16'h0000);
    endtask : t_timeout

    // test end and write-one-clear in the same cycle: the event must stay set
    task automatic t_set_wins;
        wr(`PACD_ADDR_SCD, 16'h1000);
        @(posedge sys_clk);
        cable_test_done <= 1'b1;
        @(posedge sys_clk);
        cable_test_done <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= `PACD_ADDR_INT_STAT;
        reg_wdata <= 16'h0001;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        rd_chk(`PACD_ADDR_INT_STAT, 16'h0001);
        wr(`PACD_ADDR_INT_STAT, 16'h0001);
        rd_chk(`PACD_ADDR_INT_STAT, 16'h0000);
    endtask : t_set_wins

    // reset dropped while a test runs
    task automatic t_midreset;
        wr(`PACD_ADDR_SCD, 16'h1a00);
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        #1;
        check({12'h0, cable_test_start, force_link, remote_loopback, irq}, 16'h0000);
        rd_chk(`PACD_ADDR_SCD, 16'h0000);
        rd_chk(`PACD_ADDR_ADV, 16'h05e1);
        rd_chk(`PACD_ADDR_INT_MASK, 16'h0000);
    endtask : t_midreset

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc >= 3000) begin
            err_total++;
            give_verdict;
        end
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset;
        t_adv;
        t_partner;
        t_rsvd;
        t_cable;
        t_set_wins;
        t_timeout;
        t_midreset;
        give_verdict;
    end
endmodule : testbench
`default_nettype wire
